// ==== rtl/cms_mailbox_sem.sv ====
`timescale 1ns/1ps
`default_nettype none
module cms_mailbox_sem #(
  parameter int N_PORTS = 4,
  parameter int OWN_W   = 3
) (
  // clock and reset
  input  wire logic                                  clk_sys,
  input  wire logic                                  reset,
  // register ports, index 0 = embedded cpu and pcie
  input  wire cms_pkg::cms_req_s                     req [N_PORTS],
  output logic [N_PORTS-1:0][cms_pkg::DATA_W-1:0]    rdata_r,
  // software interrupts
  output logic [cms_pkg::SEM_CNT-1:0]                irq_cpu,
  output logic [cms_pkg::SEM_CNT-1:0]                irq_ext
);

  localparam int SN = cms_pkg::SEM_CNT;
  localparam int DW = cms_pkg::DATA_W;

  function automatic logic hit_wr(input cms_pkg::cms_req_s r,
                                  input logic [cms_pkg::ADDR_W-1:0] a);
    hit_wr = r.wr && (r.addr == a);
  endfunction : hit_wr

  function automatic logic hit_rd(input cms_pkg::cms_req_s r,
                                  input logic [cms_pkg::ADDR_W-1:0] a);
    hit_rd = r.rd && (r.addr == a);
  endfunction : hit_rd

  logic [DW-1:0]                mbox_r;
  logic [DW-1:0]                mbox_nxt;
  logic [SN-1:0]                pol_r;
  logic [SN-1:0]                pol_nxt;
  logic [SN-1:0]                force_r;
  logic [SN-1:0]                force_nxt;
  logic [SN-1:0]                route_r;
  logic [SN-1:0]                route_nxt;
  logic [N_PORTS-1:0]           take0;
  logic [N_PORTS-1:0]           take1;
  logic                         rel0;
  logic                         rel1;
  logic [N_PORTS-1:0]           grant0;
  logic [N_PORTS-1:0]           grant1;
  logic [OWN_W-1:0]             own0;
  logic [OWN_W-1:0]             own1;
  logic [SN-1:0]                taken;
  logic [SN-1:0]                sem_irq;
  logic [SN-1:0]                soft_irq;
  logic [N_PORTS-1:0][DW-1:0]   rd_val;

  always_comb
  begin
    rel0 = 1'b0;
    rel1 = 1'b0;
    for (int i = 0; i < N_PORTS; i++)
    begin
      take0[i] = hit_rd(req[i], cms_pkg::SEM_ZERO_ADDR);
      take1[i] = hit_rd(req[i], cms_pkg::SEM_ONE_ADDR);
      if (hit_wr(req[i], cms_pkg::SEM_ZERO_ADDR) && req[i].wdata[cms_pkg::TAKE_BIT])
        rel0 = 1'b1;
      if (hit_wr(req[i], cms_pkg::SEM_ONE_ADDR) && req[i].wdata[cms_pkg::TAKE_BIT])
        rel1 = 1'b1;
    end
  end

  cms_semaphore #(
    .N_PORTS (N_PORTS),
    .OWN_W   (OWN_W)
  ) u_sem_zero (
    .clk_sys     (clk_sys),
    .reset       (reset),
    .take_req    (take0),
    .release_req (rel0),
    .grant       (grant0),
    .owner_r     (own0)
  );

  cms_semaphore #(
    .N_PORTS (N_PORTS),
    .OWN_W   (OWN_W)
  ) u_sem_one (
    .clk_sys     (clk_sys),
    .reset       (reset),
    .take_req    (take1),
    .release_req (rel1),
    .grant       (grant1),
    .owner_r     (own1)
  );

  // plain writes first (lowest port last, so it wins), then clears, then sets;
  // masks from all ports merge; where a set and a clear hit the same bit in one cycle, the set wins
  always_comb
  begin
    mbox_nxt  = mbox_r;
    pol_nxt   = pol_r;
    force_nxt = force_r;
    route_nxt = route_r;
    for (int i = N_PORTS - 1; i >= 0; i--)
    begin
      if (hit_wr(req[i], cms_pkg::MAILBOX_ADDR))
        mbox_nxt = req[i].wdata;
      if (hit_wr(req[i], cms_pkg::SEM_CFG_ADDR))
        pol_nxt = req[i].wdata[SN-1:0];
      if (hit_wr(req[i], cms_pkg::IRQ_FORCE_ADDR))
        force_nxt = req[i].wdata[SN-1:0];
      if (hit_wr(req[i], cms_pkg::IRQ_ROUTE_ADDR))
        route_nxt = req[i].wdata[SN-1:0];
    end
    for (int i = 0; i < N_PORTS; i++)
    begin
      if (hit_wr(req[i], cms_pkg::MAILBOX_BIT_CLEAR_MASK_ADDR))
        mbox_nxt = mbox_nxt & ~req[i].wdata;
    end
    for (int i = 0; i < N_PORTS; i++)
    begin
      if (hit_wr(req[i], cms_pkg::MAILBOX_SET_ADDR))
        mbox_nxt = mbox_nxt | req[i].wdata;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      mbox_r  <= cms_pkg::MAILBOX_RST;
      pol_r   <= cms_pkg::CFG_RST;
      force_r <= cms_pkg::FORCE_RST;
      route_r <= cms_pkg::ROUTE_RST;
    end
    else
    begin
      mbox_r  <= mbox_nxt;
      pol_r   <= pol_nxt;
      force_r <= force_nxt;
      route_r <= route_nxt;
    end
  end

  // read mux; set/clear masks read as zero, unmapped reads as zero
  always_comb
  begin
    for (int i = 0; i < N_PORTS; i++)
    begin
      rd_val[i] = cms_pkg::READ_ZERO;
      case (req[i].addr)
        cms_pkg::MAILBOX_ADDR:      rd_val[i] = mbox_r;
        cms_pkg::SEM_CFG_ADDR:      rd_val[i][SN-1:0] = pol_r;
        cms_pkg::SEM_ZERO_ADDR:     rd_val[i][cms_pkg::TAKE_BIT] = grant0[i];
        cms_pkg::SEM_ONE_ADDR:      rd_val[i][cms_pkg::TAKE_BIT] = grant1[i];
        cms_pkg::SEM_ZERO_OWN_ADDR: rd_val[i][OWN_W-1:0] = own0;
        cms_pkg::SEM_ONE_OWN_ADDR:  rd_val[i][OWN_W-1:0] = own1;
        cms_pkg::IRQ_FORCE_ADDR:    rd_val[i][SN-1:0] = force_r;
        cms_pkg::IRQ_ROUTE_ADDR:    rd_val[i][SN-1:0] = route_r;
        default:                    rd_val[i] = cms_pkg::READ_ZERO;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys)
  begin
    for (int i = 0; i < N_PORTS; i++)
    begin
      if (reset || !req[i].rd)
        rdata_r[i] <= cms_pkg::READ_ZERO;
      else
        rdata_r[i] <= rd_val[i];
    end
  end

  assign taken    = {(own1 != '0), (own0 != '0)};
  assign sem_irq  = (pol_r & taken) | (~pol_r & ~taken);
  assign soft_irq = sem_irq | force_r;

  // outputs are combinational from registers; a consumer should treat them as levels
  assign irq_cpu = soft_irq & ~route_r;
  assign irq_ext = soft_irq & route_r;

endmodule : cms_mailbox_sem
`default_nettype wire

// ==== include/cms_pkg.sv ====
`default_nettype none
package cms_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte addresses, one aligned word each
  localparam logic [ADDR_W-1:0] MAILBOX_ADDR      = 8'h00;
  localparam logic [ADDR_W-1:0] MAILBOX_SET_ADDR  = 8'h04;
  localparam logic [ADDR_W-1:0] MAILBOX_BIT_CLEAR_MASK_ADDR  = 8'h08;
  localparam logic [ADDR_W-1:0] SEM_CFG_ADDR      = 8'h0C;
  localparam logic [ADDR_W-1:0] SEM_ZERO_ADDR     = 8'h10;
  localparam logic [ADDR_W-1:0] SEM_ONE_ADDR      = 8'h14;
  localparam logic [ADDR_W-1:0] SEM_ZERO_OWN_ADDR = 8'h18;
  localparam logic [ADDR_W-1:0] SEM_ONE_OWN_ADDR  = 8'h1C;
  localparam logic [ADDR_W-1:0] IRQ_FORCE_ADDR    = 8'h20;
  localparam logic [ADDR_W-1:0] IRQ_ROUTE_ADDR    = 8'h24;

  localparam int SEM_CNT  = 2;
  localparam int TAKE_BIT = 0;

  localparam logic [DATA_W-1:0]  MAILBOX_RST = 32'h0000_0000;
  localparam logic [SEM_CNT-1:0] CFG_RST     = 2'h0;
  localparam logic [SEM_CNT-1:0] FORCE_RST   = 2'h0;
  localparam logic [SEM_CNT-1:0] ROUTE_RST   = 2'h0;
  localparam logic [DATA_W-1:0]  READ_ZERO   = 32'h0000_0000;

  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } cms_req_s;

endpackage : cms_pkg
`default_nettype wire

// ==== rtl/cms_semaphore.sv ====
`timescale 1ns/1ps
`default_nettype none
module cms_semaphore #(
  parameter int N_PORTS = 4,
  parameter int OWN_W   = 3
) (
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               reset,
  // requests from the register ports
  input  wire logic [N_PORTS-1:0] take_req,
  input  wire logic               release_req,
  // state
  output logic [N_PORTS-1:0]      grant,
  output logic [OWN_W-1:0]        owner_r
);

  localparam logic [OWN_W-1:0] OWN_FREE = '0;

  logic [OWN_W-1:0] owner_nxt;
  logic             is_free;

  assign is_free = (owner_r == OWN_FREE);

  // lowest port index wins when several read a free semaphore together
  always_comb
  begin
    grant = '0;
    if (is_free)
    begin
      for (int i = N_PORTS - 1; i >= 0; i--)
      begin
        if (take_req[i])
        begin
          grant    = '0;
          grant[i] = 1'b1;
        end
      end
    end
  end

  // a take in the same cycle as a release of a held semaphore fails: grant needs a free owner, so the release frees it
  always_comb
  begin
    owner_nxt = owner_r;
    if (release_req)
      owner_nxt = OWN_FREE;
    for (int i = 0; i < N_PORTS; i++)
    begin
      if (grant[i])
        owner_nxt = OWN_W'(i + 1);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      owner_r <= OWN_FREE;
    else
      owner_r <= owner_nxt;
  end

endmodule : cms_semaphore
`default_nettype wire

// ==== test/cms_mailbox_sem_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module cms_mailbox_sem_monitor #(
  parameter int N_PORTS = 4
) (
  // clock and reset
  input wire logic                                    clk_sys,
  input wire logic                                    reset,
  // register ports
  input wire cms_pkg::cms_req_s                       req [N_PORTS],
  input wire logic [N_PORTS-1:0][cms_pkg::DATA_W-1:0] rdata_r,
  // software interrupts
  input wire logic [cms_pkg::SEM_CNT-1:0]             irq_cpu,
  input wire logic [cms_pkg::SEM_CNT-1:0]             irq_ext
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // helpers assume four ports; other writers would spoil the mailbox relations
  wire logic nw  = !(req[0].wr || req[1].wr || req[2].wr || req[3].wr);
  wire logic w0  = req[0].wr && !(req[1].wr || req[2].wr || req[3].wr);
  wire logic mr0 = req[0].rd && req[0].addr == cms_pkg::MAILBOX_ADDR && nw;
  wire logic t1  = req[1].rd && req[1].addr == cms_pkg::SEM_ZERO_ADDR && nw;
  wire logic t2  = req[2].rd && req[2].addr == cms_pkg::SEM_ZERO_ADDR && nw;
  wire logic o1  = req[1].rd && req[1].addr == cms_pkg::SEM_ZERO_OWN_ADDR && nw;

  plain_word_a: assert property (w0 && req[0].addr == cms_pkg::MAILBOX_ADDR ##1 mr0
    |=> rdata_r[0] == $past(req[0].wdata, 2)) else $error("mailbox readback wrong");
  set_mask_a: assert property (w0 && req[0].addr == cms_pkg::MAILBOX_SET_ADDR ##1 mr0
    |=> (rdata_r[0] & $past(req[0].wdata, 2)) == $past(req[0].wdata, 2))
    else $error("set mask bits missing");
  clr_mask_a: assert property (w0 && req[0].addr == cms_pkg::MAILBOX_BIT_CLEAR_MASK_ADDR ##1 mr0
    |=> (rdata_r[0] & $past(req[0].wdata, 2)) == 32'h0) else $error("clear mask bits left");
  read_idle_a: assert property (!req[1].rd |=> rdata_r[1] == 32'h0)
    else $error("read data outside answer cycle");
  take_owner_a: assert property (t1 ##1 (rdata_r[1] == 32'h1 && o1)
    |=> rdata_r[1] == 32'h2) else $error("owner code after take wrong");
  taken_zero_a: assert property (t1 ##1 nw ##1 t2 |=> rdata_r[2] == 32'h0)
    else $error("second take succeeded");
  one_winner_a: assert property (req[2].rd && req[3].rd
    && req[2].addr == cms_pkg::SEM_ONE_ADDR && req[3].addr == cms_pkg::SEM_ONE_ADDR
    |=> !(rdata_r[2][0] && rdata_r[3][0])) else $error("two winners");
  unmapped_a: assert property (req[3].rd && req[3].addr > cms_pkg::IRQ_ROUTE_ADDR
    |=> rdata_r[3] == 32'h0) else $error("unmapped read not zero");
  one_route_a: assert property ((irq_cpu & irq_ext) == 2'h0)
    else $error("interrupt on both outputs");
endmodule : cms_mailbox_sem_monitor

bind cms_mailbox_sem cms_mailbox_sem_monitor #(.N_PORTS(N_PORTS)) mon_u (.clk_sys(clk_sys),
  .reset(reset), .req(req), .rdata_r(rdata_r), .irq_cpu(irq_cpu), .irq_ext(irq_ext));
`default_nettype wire

// ==== test/cms_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module cms_host_model (
  // clock
  input  wire logic             clk_sys,
  // register ports
  output var cms_pkg::cms_req_s req [4],
  input  wire logic [3:0][31:0] rdata_r,
  // answer seen by each port
  output var logic [3:0][31:0]  seen
);
  initial
  begin
    for (int i = 0; i < 4; i++)
      req[i] = '0;
    seen = '0;
  end
  // one strobe cycle on every port in the masks; released lines invert so stale values never match
  task automatic go(input logic [3:0] rm, input logic [3:0] wm, input logic [7:0] a,
                    input logic [31:0] d);
    for (int i = 0; i < 4; i++)
      req[i] <= '{rd: rm[i], wr: wm[i], addr: a, wdata: d};
    @(posedge clk_sys);
    for (int i = 0; i < 4; i++)
      req[i] <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    #1;
    seen = rdata_r;
  endtask : go
endmodule : cms_host_model
`default_nettype wire

// ==== test/cms_mailbox_sem_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module cms_mailbox_sem_tb;
  logic              clk_sys;
  logic              reset;
  cms_pkg::cms_req_s req [4];
  logic [3:0][31:0]  rdata_r;
  logic [3:0][31:0]  seen;
  logic [1:0]        irq_cpu;
  logic [1:0]        irq_ext;
  int                n_mismatch = 0;
  int                samples_checked = 0;

  cms_mailbox_sem dut_u (.clk_sys(clk_sys), .reset(reset), .req(req), .rdata_r(rdata_r),
    .irq_cpu(irq_cpu), .irq_ext(irq_ext));
  cms_host_model hp_u (.clk_sys(clk_sys), .req(req), .rdata_r(rdata_r), .seen(seen));

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input int p, input logic [7:0] a, input logic [31:0] d);
    hp_u.go(4'h0, 4'(1 << p), a, d);
  endtask : wr

  task automatic rdc(input int p, input logic [7:0] a, input logic [31:0] exp);
    hp_u.go(4'(1 << p), 4'h0, a, 32'h0);
    chk(seen[p], exp);
  endtask : rdc

  task automatic complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  initial
  begin
    repeat (3000) @(posedge clk_sys);
    n_mismatch++;
    complete_run();
  end

  initial
  begin
    reset = 1'b1;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    #1;
    chk({28'h0, irq_ext, irq_cpu}, 32'h3);
    wr(0, 8'h00, 32'hA5A5_0F0F);
    rdc(0, 8'h00, 32'hA5A5_0F0F);
    wr(0, 8'h04, 32'h0000_F000);
    rdc(0, 8'h00, 32'hA5A5_FF0F);
    wr(0, 8'h08, 32'hA500_000F);
    rdc(0, 8'h00, 32'h00A5_FF00);
    wr(3, 8'h04, 32'h8000_0000);
    rdc(1, 8'h00, 32'h80A5_FF00);
    rdc(3, 8'h40, 32'h0);
    rdc(1, 8'h04, 32'h0);
    rdc(1, 8'h10, 32'h1);
    rdc(1, 8'h18, 32'h2);
    rdc(2, 8'h10, 32'h0);
    rdc(3, 8'h1C, 32'h0);
    chk({28'h0, irq_ext, irq_cpu}, 32'h2);
    wr(3, 8'h10, 32'h1);
    rdc(2, 8'h18, 32'h0);
    hp_u.go(4'hC, 4'h0, 8'h14, 32'h0);
    chk(seen[2], 32'h1);
    chk(seen[3], 32'h0);
    rdc(0, 8'h1C, 32'h3);
    rdc(0, 8'h10, 32'h1);
    rdc(2, 8'h18, 32'h1);
    chk({28'h0, irq_ext, irq_cpu}, 32'h0);
    wr(1, 8'h0C, 32'h1);
    chk({28'h0, irq_ext, irq_cpu}, 32'h1);
    wr(1, 8'h24, 32'h1);
    chk({28'h0, irq_ext, irq_cpu}, 32'h4);
    wr(2, 8'h20, 32'h2);
    chk({28'h0, irq_ext, irq_cpu}, 32'h6);
    rdc(0, 8'h0C, 32'h1);
    rdc(3, 8'h24, 32'h1);
    rdc(1, 8'h20, 32'h2);
    // a write with the take bit low must leave the owner in place
    wr(2, 8'h10, 32'h0);
    rdc(2, 8'h18, 32'h1);
    complete_run();
  end
endmodule : cms_mailbox_sem_tb
`default_nettype wire
